// *** src/pts_pkg.sv ***
// shared constants, encodings and the check-code function for the sensor link
// assumes a 50 MHz system clock on both ends
package pts_pkg;
	// link address and command encodings
	localparam logic [6:0]  I2C_ADDR       = 7'h76;
	localparam logic [7:0]  CMD_RESET      = 8'h1e;
	localparam logic [7:0]  CMD_ADC_READ   = 8'h00;
	localparam logic [7:0]  CMD_PROM_BASE  = 8'ha0;
	localparam logic [3:0]  PROM_NIBBLE    = 4'ha;
	localparam logic [2:0]  CONV_TOP       = 3'h2;
	localparam int          CMD_KIND_POS   = 4;
	localparam logic [2:0]  PROM_LAST_IDX  = 3'h6;
	localparam logic [2:0]  RATIO_LAST     = 3'h4;
	localparam int          PROM_WORDS     = 7;
	localparam int          RATIO_COUNT    = 5;
	localparam int          RESULT_BITS    = 24;
	localparam int          CNT_BITS       = 20;
	localparam logic [3:0]  RECOVER_PULSES = 4'h9;
	// word 0 layout and check code
	localparam int          W0_CRC_LSB     = 12;
	localparam logic [15:0] CRC_MASK       = 16'h0fff;
	localparam logic [15:0] CRC_POLY       = 16'h3000;
	// arbitrary contents of the calibration store
	localparam logic [6:0]  VERSION_DEFAULT = 7'h3a;
	localparam logic [4:0]  CFG_DEFAULT     = 5'h05;
	localparam logic [5:0][15:0] COEF_DEFAULT = {16'h6c2e, 16'h7184, 16'h2a4d, 16'h1b31, 16'h9e12, 16'h8f47};
	// timing
	localparam real         CLK_PERIOD_NS  = 20.0;
	localparam int          CLK_KHZ        = 50000;
	localparam int          SCL_MAX_KHZ    = 400;
	localparam int          SCL_QTR_CYC    = (CLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
	typedef real         pts_ms_t  [RATIO_COUNT];
	typedef int unsigned pts_cyc_t [RATIO_COUNT];
	localparam pts_ms_t     CONV_TIME_MS   = '{0.56, 1.10, 2.17, 4.32, 8.61};
	localparam real         CONV_TIME_8192_MS = 17.2;
	function automatic int unsigned ptsMsToCyc(input real ms);
		return $rtoi($ceil(ms * 1.0e6 / CLK_PERIOD_NS));
	endfunction
	localparam pts_cyc_t    CONV_CYC = '{ptsMsToCyc(CONV_TIME_MS[0]), ptsMsToCyc(CONV_TIME_MS[1]),
		ptsMsToCyc(CONV_TIME_MS[2]), ptsMsToCyc(CONV_TIME_MS[3]), ptsMsToCyc(CONV_TIME_MS[4])};
	// host register map
	localparam logic [7:0]  REG_CMD        = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam logic [7:0]  REG_RESULT     = 8'h08;
	localparam logic [7:0]  REG_CAL0       = 8'h10;
	localparam int          CMD_KIND_BIT   = 2;
	localparam int          CMD_RATIO_LSB  = 3;
	typedef enum logic [1:0] {
		OP_RESET   = 2'b00,
		OP_CAL     = 2'b01,
		OP_CONV    = 2'b10,
		OP_RECOVER = 2'b11
	} pts_op_e;
	typedef enum logic [1:0] {
		RD_NONE = 2'b00,
		RD_PROM = 2'b01,
		RD_ADC  = 2'b10
	} pts_rd_e;

	// bytes taken msb first, word 0 masked, word 7 forced to zero
	function automatic logic [3:0] ptsCrc4(input logic [7:0][15:0] words);
		logic [15:0]       rem;
		logic [7:0][15:0]  w;
		rem = '0;
		w = words;
		w[0] = w[0] & CRC_MASK;
		w[7] = '0;
		for (int c = 0; c < 16; c++) begin
			rem = rem ^ {8'h00, (c % 2 == 1) ? w[c >> 1][7:0] : w[c >> 1][15:8]};
			for (int b = 0; b < 8; b++)
				rem = rem[15] ? ((rem << 1) ^ CRC_POLY) : (rem << 1);
		end
		return rem[15:12];
	endfunction
endpackage

// *** src/pts_i2c_if.sv ***
// two-wire link between the host controller and the sensor
// open-drain data pulled high when nobody drives low; clock driven by host only
`timescale 1ns/1ps
interface pts_i2c_if;
	logic hostScl;
	logic hostSdaO;
	logic hostSdaOe;
	logic devSdaO;
	logic devSdaOe;
	logic scl;
	logic sda;
	assign scl = hostScl;
	assign sda = ~((hostSdaOe & ~hostSdaO) | (devSdaOe & ~devSdaO));
	modport host (output hostScl, hostSdaO, hostSdaOe, input sda);
	modport dev  (input scl, sda, output devSdaO, devSdaOe);
endinterface

// *** src/pts_sensor_dev.sv ***
// sensor end: two-wire target, command decode, calibration store, conversion timer
// assumes link pins arrive asynchronously; raw values come from same-clock logic
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module pts_sensor_dev import pts_pkg::*; #(
	parameter pts_cyc_t         CONV_CYC_P  = CONV_CYC,
	parameter logic [6:0]       VERSION     = VERSION_DEFAULT,
	parameter logic [4:0]       FACTORY_CFG = CFG_DEFAULT,
	parameter logic [5:0][15:0] COEF        = COEF_DEFAULT
) (
	// system
	input  wire logic                   clock,
	input  wire logic                   srst,
	input  wire logic                   ce,
	// link
	pts_i2c_if.dev                      link,
	// sensing element
	input  wire logic [RESULT_BITS-1:0] rawPressureValue,
	input  wire logic [RESULT_BITS-1:0] rawTemperatureValue,
	// status
	output logic                        converting,
	output logic                        calReady
);
	typedef enum logic [2:0] {
		L_IDLE = 3'b000,
		L_ADDR = 3'b001,
		L_AACK = 3'b010,
		L_CMD  = 3'b011,
		L_CACK = 3'b100,
		L_TX   = 3'b101,
		L_MACK = 3'b110
	} pts_link_st_e;
	typedef logic [CNT_BITS-1:0] pts_cnt_t;

	for (genvar i = 0; i < RATIO_COUNT; i++) begin : g_chk
		if (CONV_CYC_P[i] < 1 || CONV_CYC_P[i] >= (1 << CNT_BITS))
			$error("conversion cycle count out of range");
	end

	// calibration image; check code computed over the rest
	localparam logic [7:0][15:0] ROM_NOCRC = {16'h0000, COEF, 4'h0, VERSION, FACTORY_CFG};
	localparam logic [3:0]       ROM_CRC   = ptsCrc4(ROM_NOCRC);
	localparam logic [15:0]      WORD0     = {ROM_CRC, ROM_NOCRC[0][W0_CRC_LSB-1:0]};

	logic                   sclM, sclS, sclD, sdaM, sdaS, sdaD;
	logic                   sclRise, sclFall, startCond, stopCond;
	pts_link_st_e           st;
	logic [2:0]             bitCnt;
	logic [7:0]             shReg;
	logic                   byteRdy, rdDir, moreReq;
	logic [RESULT_BITS-1:0] txSh, txLoad;
	logic [1:0]             bytesLeft, txLen;
	logic                   cmdValid, adcRead;
	logic [7:0]             cmdByte;
	logic                   isReset, isProm, isConv, isAdc;
	pts_rd_e                rdKind;
	logic [2:0]             promIdx, loadIdx;
	logic                   loading, convKind, corrupt, resultFresh;
	pts_cnt_t               convCnt;
	logic [RESULT_BITS-1:0] resultReg;
	logic [15:0]            calReg [PROM_WORDS];

	// pin synchronisers; the third stage only feeds edge detection
	always_ff @(posedge clock) begin
		if (srst) begin
			{sclM, sclS, sclD, sdaM, sdaS, sdaD} <= 6'h3f;
			link.devSdaO <= 1'b0;
		end else if (ce) begin
			sclM <= link.scl;
			sclS <= sclM;
			sclD <= sclS;
			sdaM <= link.sda;
			sdaS <= sdaM;
			sdaD <= sdaS;
			link.devSdaO <= 1'b0;
		end
	end

	assign sclRise   = sclS & ~sclD;
	assign sclFall   = ~sclS & sclD;
	assign startCond = sclS & sclD & sdaD & ~sdaS;
	assign stopCond  = sclS & sclD & ~sdaD & sdaS;

	assign isReset = cmdByte == CMD_RESET;
	assign isProm  = cmdByte[7:4] == PROM_NIBBLE && !cmdByte[0] && cmdByte[3:1] <= PROM_LAST_IDX;
	assign isConv  = cmdByte[7:5] == CONV_TOP && !cmdByte[0] && cmdByte[3:1] <= RATIO_LAST;
	assign isAdc   = cmdByte == CMD_ADC_READ;

	// answer for the coming read transfer
	always_comb begin
		case (rdKind)
			RD_PROM: begin
				txLoad = {calReg[promIdx], 8'h00};
				txLen  = 2'd2;
			end
			RD_ADC: begin
				txLoad = resultFresh ? resultReg : '0;
				txLen  = 2'd3;
			end
			default: begin
				txLoad = '0;
				txLen  = 2'd3;
			end
		endcase
	end

	// bus target
	always_ff @(posedge clock) begin
		if (srst) begin
			st <= L_IDLE;
			bitCnt <= '0;
			shReg <= '0;
			byteRdy <= 1'b0;
			rdDir <= 1'b0;
			moreReq <= 1'b0;
			txSh <= '0;
			bytesLeft <= '0;
			cmdValid <= 1'b0;
			cmdByte <= '0;
			adcRead <= 1'b0;
			link.devSdaOe <= 1'b0;
		end else if (ce) begin
			cmdValid <= 1'b0;
			adcRead <= 1'b0;
			if (startCond) begin
				st <= L_ADDR;
				bitCnt <= '0;
				byteRdy <= 1'b0;
				link.devSdaOe <= 1'b0;
			end else if (stopCond) begin
				st <= L_IDLE;
				link.devSdaOe <= 1'b0;
			end else if (sclRise) begin
				case (st)
					L_ADDR, L_CMD: begin
						shReg <= {shReg[6:0], sdaS};
						bitCnt <= bitCnt + 3'd1;
						if (bitCnt == 3'd7)
							byteRdy <= 1'b1;
					end
					L_TX: bitCnt <= bitCnt + 3'd1;
					L_MACK: moreReq <= ~sdaS && bytesLeft != 2'd0;
					default: ;
				endcase
			end else if (sclFall) begin
				case (st)
					L_ADDR: if (byteRdy) begin
						byteRdy <= 1'b0;
						if (shReg[7:1] == I2C_ADDR) begin
							link.devSdaOe <= 1'b1;
							rdDir <= shReg[0];
							st <= L_AACK;
						end else
							st <= L_IDLE;
					end
					L_AACK: begin
						bitCnt <= '0;
						if (rdDir) begin
							link.devSdaOe <= ~txLoad[RESULT_BITS-1];
							txSh <= txLoad << 1;
							bytesLeft <= txLen - 2'd1;
							adcRead <= rdKind == RD_ADC;
							st <= L_TX;
						end else begin
							link.devSdaOe <= 1'b0;
							st <= L_CMD;
						end
					end
					L_CMD: if (byteRdy) begin
						byteRdy <= 1'b0;
						link.devSdaOe <= 1'b1;
						cmdValid <= 1'b1;
						cmdByte <= shReg;
						st <= L_CACK;
					end
					// further bytes of the same write are left unacknowledged
					L_CACK: begin
						link.devSdaOe <= 1'b0;
						st <= L_IDLE;
					end
					L_TX: if (bitCnt == 3'd0) begin
						link.devSdaOe <= 1'b0;
						st <= L_MACK;
					end else begin
						link.devSdaOe <= ~txSh[RESULT_BITS-1];
						txSh <= txSh << 1;
					end
					L_MACK: if (moreReq) begin
						link.devSdaOe <= ~txSh[RESULT_BITS-1];
						txSh <= txSh << 1;
						bytesLeft <= bytesLeft - 2'd1;
						bitCnt <= '0;
						st <= L_TX;
					end else
						st <= L_IDLE;
					default: st <= L_IDLE;
				endcase
			end
		end
	end

	// commands, conversion and result
	always_ff @(posedge clock) begin
		if (srst || (ce && cmdValid && isReset)) begin
			converting <= 1'b0;
			convCnt <= '0;
			convKind <= 1'b0;
			corrupt <= 1'b0;
			resultReg <= '0;
			resultFresh <= 1'b0;
			rdKind <= RD_NONE;
			promIdx <= '0;
		end else if (ce) begin
			if (adcRead)
				resultFresh <= 1'b0;
			if (cmdValid && isConv) begin
				converting <= 1'b1;
				convCnt <= pts_cnt_t'(CONV_CYC_P[cmdByte[3:1]] - 1);
				corrupt <= converting;
				convKind <= cmdByte[CMD_KIND_POS];
				resultFresh <= 1'b0;
			end else if (converting) begin
				if (convCnt == '0) begin
					converting <= 1'b0;
					corrupt <= 1'b0;
					resultFresh <= 1'b1;
					// a restarted conversion delivers a zero result
					resultReg <= corrupt ? '0 : (convKind ? rawTemperatureValue : rawPressureValue);
				end else
					convCnt <= convCnt - pts_cnt_t'(1);
			end
			if (cmdValid && isProm) begin
				rdKind <= RD_PROM;
				promIdx <= cmdByte[3:1];
			end else if (cmdValid && isAdc)
				rdKind <= RD_ADC;
		end
	end

	// calibration load at reset and on the reset command
	always_ff @(posedge clock) begin
		if (srst || (ce && cmdValid && isReset)) begin
			loading <= 1'b1;
			loadIdx <= '0;
			calReady <= 1'b0;
		end else if (ce && loading) begin
			loadIdx <= loadIdx + 3'd1;
			if (loadIdx == PROM_LAST_IDX) begin
				loading <= 1'b0;
				calReady <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!srst && ce && loading)
			calReg[loadIdx] <= (loadIdx == 3'd0) ? WORD0 : ROM_NOCRC[loadIdx];
	end
endmodule

// *** src/pts_host_ctl.sv ***
// host end: bus controller that sequences sensor commands from a register port
// assumes software on the same clock; link data input is asynchronous
`timescale 1ns/1ps
module pts_host_ctl import pts_pkg::*; #(
	parameter pts_cyc_t CONV_WAIT_P = CONV_CYC,
	parameter int       QTR         = SCL_QTR_CYC
) (
	// system
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        ce,
	// link
	pts_i2c_if.host          link,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [31:0]      regRdata
);
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_START = 3'b001,
		H_BYTE  = 3'b010,
		H_STOP  = 3'b011,
		H_WAIT  = 3'b100,
		H_PULSE = 3'b101
	} pts_host_st_e;

	if (QTR < 4 || QTR > 255)
		$error("quarter period out of range");
	for (genvar i = 0; i < RATIO_COUNT; i++) begin : g_chk
		if (CONV_WAIT_P[i] < 1 || CONV_WAIT_P[i] >= (1 << CNT_BITS))
			$error("wait count out of range");
	end

	pts_host_st_e           st;
	pts_op_e                op;
	logic [1:0]             ph, seq, byteNo, bytesTot;
	logic [7:0]             qCnt, txByte, rxByte, frameCmd, nxtCmd, calOff;
	logic [3:0]             bitNo, pulseCnt;
	logic [2:0]             wordIdx, ratio;
	logic                   kind, rdFrame, nxtRd, busy, nackErr, sdaM, sdaS, qTick, sclWant, oeWant, crcGood;
	logic                   calValid;
	logic [CNT_BITS-1:0]    waitCnt;
	logic [RESULT_BITS-1:0] acc, result;
	logic [15:0]            calWord [PROM_WORDS];

	assign qTick   = qCnt == 8'(QTR - 1);
	assign calOff  = regAddr - REG_CAL0;
	// stored words have no reset, so the match only counts once a full read has filled them
	assign crcGood = calValid && ptsCrc4({16'h0000, calWord[6], calWord[5], calWord[4], calWord[3], calWord[2], calWord[1],
		calWord[0]}) == calWord[0][15:W0_CRC_LSB];

	// next frame of the running operation
	always_comb begin
		nxtRd = 1'b0;
		nxtCmd = CMD_RESET;
		case (op)
			OP_CAL: begin
				nxtRd = seq[0];
				nxtCmd = CMD_PROM_BASE | {4'h0, wordIdx, 1'b0};
			end
			OP_CONV: begin
				nxtRd = seq == 2'd2;
				nxtCmd = (seq == 2'd0) ? {CONV_TOP, kind, ratio, 1'b0} : CMD_ADC_READ;
			end
			default: ;
		endcase
	end

	// pin levels per state and quarter phase
	always_comb begin
		sclWant = 1'b1;
		oeWant = 1'b0;
		case (st)
			H_START: begin
				sclWant = ~ph[1];
				oeWant = ph != 2'd0;
			end
			H_BYTE: begin
				sclWant = ph[1];
				if (bitNo[3])
					oeWant = rdFrame && byteNo != 2'd0 && byteNo != bytesTot;
				else
					oeWant = !(rdFrame && byteNo != 2'd0) && !txByte[7];
			end
			H_STOP: begin
				sclWant = ph != 2'd0;
				oeWant = ph[1] == 1'b0;
			end
			H_PULSE: sclWant = ph[1];
			default: ;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			sdaM <= 1'b1;
			sdaS <= 1'b1;
			link.hostScl <= 1'b1;
			link.hostSdaOe <= 1'b0;
			link.hostSdaO <= 1'b0;
		end else if (ce) begin
			sdaM <= link.sda;
			sdaS <= sdaM;
			link.hostScl <= sclWant;
			link.hostSdaOe <= oeWant;
			link.hostSdaO <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st <= H_IDLE;
			op <= OP_RESET;
			{ph, seq, byteNo, bytesTot, bitNo, pulseCnt, wordIdx, ratio} <= '0;
			{qCnt, txByte, rxByte, frameCmd} <= '0;
			{kind, rdFrame, busy, nackErr} <= '0;
			waitCnt <= '0;
			acc <= '0;
			result <= '0;
		end else if (ce) begin
			if (st == H_IDLE) begin
				if (regWr && regAddr == REG_CMD && regWdata[CMD_RATIO_LSB +: 3] <= RATIO_LAST) begin
					op <= pts_op_e'(regWdata[1:0]);
					kind <= regWdata[CMD_KIND_BIT];
					ratio <= regWdata[CMD_RATIO_LSB +: 3];
					{seq, wordIdx, pulseCnt, ph, qCnt} <= '0;
					nackErr <= 1'b0;
					busy <= 1'b1;
					st <= (regWdata[1:0] == OP_RECOVER) ? H_PULSE : H_START;
				end
			end else if (st == H_WAIT) begin
				waitCnt <= waitCnt - 1'b1;
				if (waitCnt == '0)
					st <= H_START;
			end else if (!qTick)
				qCnt <= qCnt + 8'd1;
			else begin
				qCnt <= '0;
				ph <= ph + 2'd1;
				if (ph == 2'd3) begin
					case (st)
						H_START: begin
							rdFrame <= nxtRd;
							frameCmd <= nxtCmd;
							bytesTot <= nxtRd ? ((op == OP_CONV) ? 2'd3 : 2'd2) : 2'd1;
							txByte <= {I2C_ADDR, nxtRd};
							{byteNo, bitNo} <= '0;
							st <= H_BYTE;
						end
						H_BYTE: if (!bitNo[3]) begin
							rxByte <= {rxByte[6:0], sdaS};
							txByte <= txByte << 1;
							bitNo <= bitNo + 4'd1;
						end else begin
							if ((!rdFrame || byteNo == 2'd0) && sdaS)
								nackErr <= 1'b1;
							if (rdFrame && byteNo != 2'd0)
								acc <= {acc[15:0], rxByte};
							bitNo <= '0;
							byteNo <= byteNo + 2'd1;
							txByte <= frameCmd;
							if (byteNo == bytesTot)
								st <= H_STOP;
						end
						H_PULSE: begin
							pulseCnt <= pulseCnt + 4'd1;
							if (sdaS || pulseCnt == RECOVER_PULSES - 4'd1)
								st <= H_STOP;
						end
						H_STOP: begin
							st <= H_START;
							case (op)
								OP_CAL: begin
									seq <= {1'b0, ~seq[0]};
									if (seq[0]) begin
										wordIdx <= wordIdx + 3'd1;
										if (wordIdx == PROM_LAST_IDX) begin
											st <= H_IDLE;
											busy <= 1'b0;
										end
									end
								end
								OP_CONV: begin
									seq <= seq + 2'd1;
									if (seq == 2'd0) begin
										waitCnt <= CNT_BITS'(CONV_WAIT_P[ratio]);
										st <= H_WAIT;
									end else if (seq == 2'd2) begin
										result <= acc;
										st <= H_IDLE;
										busy <= 1'b0;
									end
								end
								OP_RECOVER: op <= OP_RESET;
								default: begin
									st <= H_IDLE;
									busy <= 1'b0;
								end
							endcase
						end
						default: st <= H_IDLE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (ce && st == H_STOP && op == OP_CAL && seq[0] && qTick && ph == 2'd3)
			calWord[wordIdx] <= acc[15:0];
	end

	always_ff @(posedge clock) begin
		if (srst)
			calValid <= 1'b0;
		else if (ce && st == H_STOP && op == OP_CAL && seq[0] && qTick && ph == 2'd3 && wordIdx == PROM_LAST_IDX)
			calValid <= 1'b1;
	end

	always_ff @(posedge clock) begin
		if (srst)
			regRdata <= '0;
		else if (ce) begin
			regRdata <= '0;
			if (regRd) begin
				if (regAddr == REG_STATUS)
					regRdata <= {29'h0, nackErr, crcGood, busy};
				else if (regAddr == REG_RESULT)
					regRdata <= {8'h00, result};
				else if (calOff[7:5] == 3'h0 && calOff[1:0] == 2'h0 && calOff[4:2] <= PROM_LAST_IDX)
					regRdata <= {16'h0000, calWord[calOff[4:2]]};
			end
		end
	end
endmodule

// *** tb/pts_link_monitor.sv ***
// checker for the two-wire sensor link: framing, acknowledge and drive rules
// assumes the link is sampled by the one clock that runs both ends
`timescale 1ns/1ps
module pts_link_monitor import pts_pkg::*; (
	// system
	input wire logic clock,
	input wire logic srst,
	// link
	input wire logic hostScl,
	input wire logic hostSdaO,
	input wire logic hostSdaOe,
	input wire logic devSdaO,
	input wire logic devSdaOe,
	input wire logic scl,
	input wire logic sda
);
	logic       sclPrev_reg;
	logic       sdaPrev_reg;
	logic       inFrame_reg;
	logic       rw_reg;
	logic [3:0] bitCnt_reg;
	logic [1:0] byteCnt_reg;
	logic [7:0] shift_reg;
	logic       sclRise;
	logic       sclFall;
	logic       ninth;
	assign sclRise = scl & ~sclPrev_reg;
	assign sclFall = ~scl & sclPrev_reg;
	assign ninth   = sclRise & inFrame_reg & (bitCnt_reg == 4'h8);

	always_ff @(posedge clock) begin
		sclPrev_reg <= scl;
		sdaPrev_reg <= sda;
	end
	// start and stop are data edges while the clock is high
	always_ff @(posedge clock) begin
		if (srst || (scl && sclPrev_reg && sda && !sdaPrev_reg))
			inFrame_reg <= 1'b0;
		else if (scl && sclPrev_reg && !sda && sdaPrev_reg)
			inFrame_reg <= 1'b1;
	end
	always_ff @(posedge clock) begin
		if (srst || !inFrame_reg) begin
			bitCnt_reg  <= 4'h0;
			byteCnt_reg <= 2'h0;
		end else if (sclRise) begin
			bitCnt_reg <= (bitCnt_reg == 4'h8) ? 4'h0 : bitCnt_reg + 4'h1;
			if (bitCnt_reg == 4'h8 && byteCnt_reg != 2'h3)
				byteCnt_reg <= byteCnt_reg + 2'h1;
		end
	end
	always_ff @(posedge clock) begin
		if (sclRise)
			shift_reg <= {shift_reg[6:0], sda};
	end
	always_ff @(posedge clock) begin
		if (srst)
			rw_reg <= 1'b0;
		else if (ninth && byteCnt_reg == 2'h0)
			rw_reg <= shift_reg[0];
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	sequence s_addrSlot;
		ninth && byteCnt_reg == 2'h0;
	endsequence
	// only the address and the one command byte of a write get a device acknowledge
	sequence s_ackFall;
		sclFall && inFrame_reg && bitCnt_reg == 4'h8 && (byteCnt_reg == 2'h0 || (byteCnt_reg == 2'h1 && !rw_reg));
	endsequence

	property p_hostOd; hostSdaO == 1'b0; endproperty
	property p_devOd; devSdaO == 1'b0; endproperty
	property p_resetIdle; @(posedge clock) disable iff (1'b0) srst |=> hostScl && !hostSdaOe && !devSdaOe; endproperty
	property p_addr; s_addrSlot |-> shift_reg[7:1] == I2C_ADDR; endproperty
	property p_addrAck; s_addrSlot |-> devSdaOe && !sda; endproperty
	property p_cmdAck; ninth && byteCnt_reg == 2'h1 && !rw_reg |-> devSdaOe; endproperty
	property p_ackStart; s_ackFall |-> ##[1:10] devSdaOe; endproperty
	property p_devLaunch; $rose(devSdaOe) |-> !scl; endproperty
	property p_readFree; ninth && byteCnt_reg != 2'h0 && rw_reg |-> !devSdaOe; endproperty
	property p_sclHigh; $rose(hostScl) |=> hostScl [*7]; endproperty

	a_hostOd: assert property (p_hostOd)
		else $error("host drives data high");
	a_devOd: assert property (p_devOd)
		else $error("device drives data high");
	a_resetIdle: assert property (p_resetIdle)
		else $error("link not idle after reset");
	a_addr: assert property (p_addr)
		else $error("wrong target address on link");
	a_addrAck: assert property (p_addrAck)
		else $error("address not acknowledged");
	a_cmdAck: assert property (p_cmdAck)
		else $error("command byte not acknowledged");
	a_ackStart: assert property (p_ackStart)
		else $error("acknowledge drive late");
	a_devLaunch: assert property (p_devLaunch)
		else $error("device changed data while clock high");
	a_readFree: assert property (p_readFree)
		else $error("device drives in host acknowledge slot");
	a_sclHigh: assert property (p_sclHigh)
		else $error("link clock high phase too short");
endmodule

// *** tb/pts_sensor_i2c_cmd_test.sv ***
// self-checking bench: host controller and sensor joined over the link
// assumes one 50 MHz clock for both ends; conversion counts are shortened
`timescale 1ns/1ps
module pts_sensor_i2c_cmd_test import pts_pkg::*; ;
	// host waits must stay longer than the device conversions
	localparam pts_cyc_t DEV_CYC  = '{32'd40, 32'd50, 32'd60, 32'd70, 32'd80};
	localparam pts_cyc_t HOST_CYC = '{32'd60, 32'd70, 32'd80, 32'd90, 32'd100};
	typedef struct packed {
		logic [5:0]  cmd;
		logic [23:0] raw;
	} pts_row_s;
	pts_row_s    rows [10] = '{'{6'h02, 24'hffffff}, '{6'h0a, 24'h000001}, '{6'h12, 24'h800000},
		'{6'h1a, 24'h7fffff}, '{6'h22, 24'ha5c3e1}, '{6'h06, 24'h123456}, '{6'h0e, 24'hfedcba},
		'{6'h16, 24'h00ff00}, '{6'h1e, 24'h0f0f0f}, '{6'h26, 24'h9abcde}};
	logic        clock;
	logic        srst;
	logic        ce;
	logic [23:0] rawPres;
	logic [23:0] rawTemp;
	logic        converting;
	logic        calReady;
	logic        sawCalLow;
	logic        sawConv;
	logic [7:0]  regAddr;
	logic [31:0] regWdata;
	logic [31:0] regRdata;
	logic [31:0] rdVal;
	logic        regWr;
	logic        regRd;
	int          nFail;
	int          cmpCount;

	pts_i2c_if bus ();
	pts_sensor_dev #(.CONV_CYC_P(DEV_CYC)) pts_sensor_dev_i (.clock(clock), .srst(srst), .ce(ce), .link(bus),
		.rawPressureValue(rawPres), .rawTemperatureValue(rawTemp), .converting(converting), .calReady(calReady));
	pts_host_ctl #(.CONV_WAIT_P(HOST_CYC), .QTR(8)) pts_host_ctl_i (.clock(clock), .srst(srst), .ce(ce),
		.link(bus), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
	pts_link_monitor pts_link_monitor_i (.clock(clock), .srst(srst), .hostScl(bus.hostScl),
		.hostSdaO(bus.hostSdaO), .hostSdaOe(bus.hostSdaOe), .devSdaO(bus.devSdaO), .devSdaOe(bus.devSdaOe),
		.scl(bus.scl), .sda(bus.sda));

	always #(CLK_PERIOD_NS / 2.0) clock = ~clock;
	always @(posedge clock) begin
		if (calReady === 1'b0)
			sawCalLow <= 1'b1;
		if (converting === 1'b1)
			sawConv <= 1'b1;
	end

	task automatic stop_test();
		$display("compares %0d, mismatches %0d", cmpCount, nFail);
		if (nFail == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nFail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1 rdVal = regRdata;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		rd(REG_STATUS);
		while (rdVal[0] !== 1'b0 && n < 20000) begin
			rd(REG_STATUS);
			n++;
		end
		if (n >= 20000) begin
			chk(rdVal & 32'h1, 32'h0);
			stop_test();
		end
	endtask

	initial begin
		clock     = 1'b0;
		srst      = 1'b1;
		ce        = 1'b1;
		rawPres   = '0;
		rawTemp   = '0;
		regAddr   = '0;
		regWdata  = '0;
		regWr     = 1'b0;
		regRd     = 1'b0;
		sawCalLow = 1'b0;
		sawConv   = 1'b0;
		nFail     = 0;
		cmpCount  = 0;
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		rd(REG_STATUS);
		chk(rdVal, 32'h0);
		repeat (10) @(posedge clock);
		chk({31'h0, calReady}, 32'h1);
		wr(REG_CMD, 32'h1);
		wait_idle();
		for (int i = 1; i < PROM_WORDS; i++) begin
			rd(REG_CAL0 + 8'(4 * i));
			chk(rdVal, {16'h0, COEF_DEFAULT[i - 1]});
		end
		rd(REG_CAL0);
		chk({20'h0, rdVal[11:0]}, {20'h0, VERSION_DEFAULT, CFG_DEFAULT});
		rd(REG_STATUS);
		chk(rdVal & 32'h7, 32'h2);
		rd(REG_CAL0 + 8'h1c);
		chk(rdVal, 32'h0);
		for (int r = 0; r < 10; r++) begin
			rawPres <= rows[r].cmd[2] ? ~rows[r].raw : rows[r].raw;
			rawTemp <= rows[r].cmd[2] ? rows[r].raw : ~rows[r].raw;
			wr(REG_CMD, {26'h0, rows[r].cmd});
			wait_idle();
			rd(REG_RESULT);
			chk(rdVal, {8'h0, rows[r].raw});
		end
		chk({31'h0, sawConv}, 32'h1);
		// second order while busy must not reach the link
		rawPres <= 24'h0a0b0c;
		rawTemp <= 24'h0d0e0f;
		wr(REG_CMD, 32'h02);
		wr(REG_CMD, 32'h06);
		wait_idle();
		rd(REG_RESULT);
		chk(rdVal, 32'h000a0b0c);
		wr(REG_CMD, 32'h2a);
		rd(REG_STATUS);
		chk(rdVal & 32'h1, 32'h0);
		sawCalLow = 1'b0;
		wr(REG_CMD, 32'h0);
		wait_idle();
		chk({31'h0, sawCalLow}, 32'h1);
		chk({31'h0, calReady}, 32'h1);
		sawCalLow = 1'b0;
		wr(REG_CMD, 32'h3);
		wait_idle();
		chk(rdVal & 32'h4, 32'h0);
		chk({31'h0, sawCalLow}, 32'h1);
		// an order written while the enable is low must be lost
		ce <= 1'b0;
		wr(REG_CMD, 32'h1);
		ce <= 1'b1;
		rd(REG_STATUS);
		chk(rdVal & 32'h1, 32'h0);
		rd(REG_RESULT);
		chk(rdVal, 32'h000a0b0c);
		sawCalLow = 1'b0;
		srst <= 1'b1;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		repeat (10) @(posedge clock);
		chk({31'h0, calReady}, 32'h1);
		chk({31'h0, sawCalLow}, 32'h1);
		rd(REG_STATUS);
		chk(rdVal, 32'h0);
		rd(REG_RESULT);
		chk(rdVal, 32'h0);
		stop_test();
	end
endmodule
